// ---- rtl/burst_col_gen.v ----
/*
 * Column address of one beat of a burst, from the start column, the beat
 * index, the burst length code and the burst type.
 * Assumes a legal length code; a reserved code behaves as length 2.
 */
`timescale 1ns/100ps
`include "ddr_mode_consts.vh"

module burst_col_gen #(
    parameter COL_W = 10
) (
    input  wire [COL_W-1:0] i_start,
    input  wire [2:0]       i_beat,
    input  wire [2:0]       i_bl_code,
    input  wire             i_interleave,
    output wire [COL_W-1:0] o_col
);
    reg  [2:0] mask;
    wire [2:0] seq_low;
    wire [2:0] low;

    always @* begin
        if (i_bl_code == `BL_CODE_8) begin
            mask = 3'h7;
        end else if (i_bl_code == `BL_CODE_4) begin
            mask = 3'h3;
        end else begin
            mask = 3'h1;
        end
    end

    // Wrap inside the aligned block; upper bits pick the block
    assign seq_low = i_start[2:0] + i_beat;
    assign low     = i_interleave ? (i_start[2:0] ^ i_beat)
                                  : seq_low;
    assign o_col   = {i_start[COL_W-1:3],
                      (i_start[2:0] & ~mask) | (low & mask)};
endmodule

// ---- rtl/ddr_mode_config_burst_logic.v ----
/*
 * Mode, extended mode, burst column sequencing, read latency timing and
 * DLL enable and lock tracking of a DDR SDRAM, seen from inside the part.
 * Assumes command pins are sampled on i_mclk by the caller's front end,
 * so they arrive in this clock's domain with no synchroniser.
 */
// What this block does
// - Burst lengths 2, 4, 8, both types
// - Burst stays in aligned block, wrapping
// - Block from upper bits, start from low
// - One burst length for reads and writes
// - Burst type taken from A3 on mode write
// - Order from length, type and start column
// - Sequential adds modulo length; interleave XORs
// - Read latency 1.5, 2, 2.5 or 3 cycles
// - First read data at edge n plus m
// - DLL off in self refresh, back after
// - Extended register holds DLL and drive controls
// - Reduced-strength driver option, about half drive
// - Extended write: mode write, BA0 high, BA1 low
// - Extended register held until rewritten
// - Mode write: all strobes low, BA0 and BA1 low
`timescale 1ns/100ps
`include "ddr_mode_consts.vh"

module ddr_mode_config_burst_logic #(
    parameter COL_W = 10
) (
    input  wire             i_mclk,
    input  wire             i_rst_b,
    input  wire             i_cke,
    input  wire             i_cs_b,
    input  wire             i_ras_b,
    input  wire             i_cas_b,
    input  wire             i_we_b,
    input  wire [1:0]       i_ba,
    input  wire [12:0]      i_addr,
    output wire             o_col_valid,
    input  wire             i_col_ready,
    output wire [COL_W-1:0] o_col,
    output wire             o_col_write,
    output wire             o_col_last,
    output wire             o_cmd_ready,
    output wire             o_rd_first,
    output wire             o_rd_half,
    output wire [2:0]       o_burst_len_code,
    output wire             o_interleave,
    output wire [2:0]       o_cas_lat_code,
    output wire             o_mode_reserved,
    output wire             o_half_drive,
    output wire             o_switch_bit_set,
    output wire             o_dll_on,
    output wire             o_dll_locked,
    output wire             o_self_refresh
);
    localparam [2:0] DLL_OFF     = 3'h1;
    localparam [2:0] DLL_LOCKING = 3'h2;
    localparam [2:0] DLL_LOCKED  = 3'h4;
    localparam [7:0] LOCK_LAST   = `DLL_LOCK_CYCLES - 1;

    reg  [12:0]      mr_r;
    reg  [12:0]      emr_r;
    reg              sref_r;
    reg  [2:0]       dll_st_r;
    reg  [2:0]       dll_st_nxt;
    reg  [7:0]       lock_cnt_r;
    reg              busy_r;
    reg  [2:0]       beat_r;
    reg  [COL_W-1:0] start_r;
    reg              wr_r;
    reg  [3:0]       rd_pipe_r;
    reg              rd_first_r;
    reg              rd_half_r;
    reg  [2:0]       len_mask;
    reg  [1:0]       lat_tap;
    reg              lat_half;
    reg              mode_bad;

    wire             sel;
    wire             cmd_mode_wr;
    wire             cmd_rd;
    wire             cmd_wr;
    wire             cmd_sref_in;
    wire             dll_want;
    wire [2:0]       bl_code;
    wire [2:0]       cl_code;
    wire [COL_W-1:0] beat_col;
    wire             last_beat;
    wire             buf_ready;

    // Command decode; pins are active low
    assign sel         = ~i_cs_b;
    assign cmd_mode_wr = sel & ~i_ras_b & ~i_cas_b & ~i_we_b;
    assign cmd_rd      = sel & i_ras_b & ~i_cas_b & i_we_b;
    assign cmd_wr      = sel & i_ras_b & ~i_cas_b & ~i_we_b;
    assign cmd_sref_in = sel & ~i_ras_b & ~i_cas_b & i_we_b & ~i_cke;

    assign bl_code = mr_r[`MR_BL_MSB:`MR_BL_LSB];
    assign cl_code = mr_r[`MR_CL_MSB:`MR_CL_LSB];

    // Mode and extended mode registers
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mr_r  <= `MR_RST_VAL;
            emr_r <= `EMR_RST_VAL;
        end else if (cmd_mode_wr) begin
            if (i_ba == `BA_MODE_REG) begin
                mr_r <= i_addr;
            end else if (i_ba == `BA_EXT_MODE_REG) begin
                emr_r <= i_addr;
            end
        end
    end
    // Extended bits otherwise held as written

    always @* begin
        if (bl_code == `BL_CODE_8) begin
            len_mask = 3'h7;
        end else if (bl_code == `BL_CODE_4) begin
            len_mask = 3'h3;
        end else begin
            len_mask = 3'h1;
        end
    end

    // Latency decode: whole cycles as a pipe tap, plus a half-cycle flag
    always @* begin
        lat_tap  = 2'h1;
        lat_half = 1'b0;
        if (cl_code == `CL_CODE_3) begin
            lat_tap = 2'h2;
        end else if (cl_code == `CL_CODE_2P5) begin
            lat_half = 1'b1;
        end else if (cl_code == `CL_CODE_1P5) begin
            lat_tap  = 2'h0;
            lat_half = 1'b1;
        end
    end

    // Reserved codes are flagged only; the block keeps running
    always @* begin
        mode_bad = 1'b0;
        if ((bl_code != `BL_CODE_2) && (bl_code != `BL_CODE_4) &&
            (bl_code != `BL_CODE_8)) begin
            mode_bad = 1'b1;
        end
        if ((cl_code != `CL_CODE_2) && (cl_code != `CL_CODE_2P5) &&
            (cl_code != `CL_CODE_3) && (cl_code != `CL_CODE_1P5)) begin
            mode_bad = 1'b1;
        end
        if (mr_r[`MR_OPM_MSB:`MR_OPM_LSB] !=
            {5'h00, mr_r[`MR_DLL_RST_BIT]} << 1) begin
            mode_bad = 1'b1;
        end
    end

    // Self refresh tracking: entered by refresh with CKE low, left on CKE
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sref_r <= 1'b0;
        end else if (cmd_sref_in) begin
            sref_r <= 1'b1;
        end else if (sref_r && i_cke) begin
            sref_r <= 1'b0;
        end
    end

    // DLL runs when enabled and not in self refresh
    assign dll_want = ~emr_r[`EMR_DLL_DIS_BIT] & ~sref_r & ~cmd_sref_in;

    always @* begin
        dll_st_nxt = dll_st_r;
        case (dll_st_r)
            DLL_OFF: begin
                if (dll_want) begin
                    dll_st_nxt = DLL_LOCKING;
                end
            end
            DLL_LOCKING: begin
                if (!dll_want) begin
                    dll_st_nxt = DLL_OFF;
                end else if (lock_cnt_r == LOCK_LAST) begin
                    dll_st_nxt = DLL_LOCKED;
                end
            end
            DLL_LOCKED: begin
                if (!dll_want) begin
                    dll_st_nxt = DLL_OFF;
                end else if (cmd_mode_wr && (i_ba == `BA_MODE_REG) &&
                             i_addr[`MR_DLL_RST_BIT]) begin
                    dll_st_nxt = DLL_LOCKING;
                end
            end
            default: begin
                dll_st_nxt = DLL_OFF;
            end
        endcase
    end

    // Lock time counts from each enable so the controller can see it
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dll_st_r   <= DLL_OFF;
            lock_cnt_r <= 8'h00;
        end else begin
            dll_st_r <= dll_st_nxt;
            if (dll_st_nxt != DLL_LOCKING || dll_st_r != DLL_LOCKING) begin
                lock_cnt_r <= 8'h00;
            end else begin
                lock_cnt_r <= lock_cnt_r + 8'h01;
            end
        end
    end

    // Burst sequencer; a new read or write cuts off the running burst
    assign last_beat = (beat_r == len_mask);

    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            busy_r  <= 1'b0;
            beat_r  <= 3'h0;
            start_r <= {COL_W{1'b0}};
            wr_r    <= 1'b0;
        end else if (cmd_rd || cmd_wr) begin
            busy_r  <= 1'b1;
            beat_r  <= 3'h0;
            start_r <= i_addr[COL_W-1:0];
            wr_r    <= cmd_wr;
        end else if (busy_r && buf_ready) begin
            if (last_beat) begin
                busy_r <= 1'b0;
            end else begin
                beat_r <= beat_r + 3'h1;
            end
        end
    end

    burst_col_gen #(
        .COL_W       (COL_W)
    ) u_col_gen (
        .i_start     (start_r),
        .i_beat      (beat_r),
        .i_bl_code   (bl_code),
        .i_interleave(mr_r[`MR_BT_BIT]),
        .o_col       (beat_col)
    );

    // Buffer absorbs receiver stalls; the sequencer waits on its ready
    two_entry_buf #(
        .W      (COL_W + 2)
    ) u_buf (
        .i_mclk (i_mclk),
        .i_rst_b(i_rst_b),
        .i_valid(busy_r),
        .o_ready(buf_ready),
        .i_data ({wr_r, last_beat, beat_col}),
        .o_valid(o_col_valid),
        .i_ready(i_col_ready),
        .o_data ({o_col_write, o_col_last, o_col})
    );

    // Read latency pipe: bit k set after edge n+k
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rd_pipe_r  <= 4'h0;
            rd_first_r <= 1'b0;
            rd_half_r  <= 1'b0;
        end else begin
            rd_pipe_r  <= {rd_pipe_r[2:0], cmd_rd};
            rd_first_r <= (lat_tap == 2'h0) ? cmd_rd
                                            : rd_pipe_r[lat_tap - 2'h1];
            rd_half_r  <= lat_half;
        end
    end

    assign o_cmd_ready      = buf_ready & ~cmd_mode_wr;
    assign o_rd_first       = rd_first_r;
    assign o_rd_half        = rd_half_r;
    assign o_burst_len_code = bl_code;
    assign o_interleave     = mr_r[`MR_BT_BIT];
    assign o_cas_lat_code   = cl_code;
    assign o_mode_reserved  = mode_bad;
    // Half drive roughly halves output current
    assign o_half_drive     = emr_r[`EMR_HALF_DRV_BIT];
    assign o_switch_bit_set = emr_r[`EMR_SWITCH_BIT];
    assign o_dll_on         = (dll_st_r != DLL_OFF);
    assign o_dll_locked     = (dll_st_r == DLL_LOCKED);
    assign o_self_refresh   = sref_r;
endmodule

// ---- rtl/ddr_mode_consts.vh ----
/*
 * Constants of the DDR mode and burst logic: mode write bank selects,
 * mode and extended mode field layout, reset values and DLL lock time.
 * Assumes it is included by bare name from the rtl files that use it.
 */
`ifndef DDR_MODE_CONSTS_VH
`define DDR_MODE_CONSTS_VH

// Mode register fields
`define MR_BL_LSB        0
`define MR_BL_MSB        2
`define MR_BT_BIT        3
`define MR_CL_LSB        4
`define MR_CL_MSB        6
`define MR_DLL_RST_BIT   8
`define MR_OPM_LSB       7
`define MR_OPM_MSB       12

// Burst length codes
`define BL_CODE_2        3'h1
`define BL_CODE_4        3'h2
`define BL_CODE_8        3'h3

// Read latency codes
`define CL_CODE_1P5      3'h5
`define CL_CODE_2        3'h2
`define CL_CODE_2P5      3'h6
`define CL_CODE_3        3'h3

// Extended mode register fields
`define EMR_DLL_DIS_BIT  0
`define EMR_HALF_DRV_BIT 1
`define EMR_SWITCH_BIT   2

// Bank address selecting the register on a mode write
`define BA_MODE_REG      2'h0
`define BA_EXT_MODE_REG  2'h1

// Reset values
`define MR_RST_VAL       13'h0021
`define EMR_RST_VAL      13'h0000

// DLL lock time in clock cycles
`define DLL_LOCK_CYCLES  200

`endif

// ---- rtl/two_entry_buf.v ----
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes one clock; the drain side may hold off ready for any time.
 */
`timescale 1ns/100ps

module two_entry_buf #(
    parameter W = 11
) (
    input  wire         i_mclk,
    input  wire         i_rst_b,
    input  wire         i_valid,
    output wire         o_ready,
    input  wire [W-1:0] i_data,
    output wire         o_valid,
    input  wire         i_ready,
    output wire [W-1:0] o_data
);
    reg [W-1:0] mem_r [0:1];
    reg         wp_r;
    reg         rp_r;
    reg [1:0]   cnt_r;
    wire        push;
    wire        pop;

    assign o_ready = (cnt_r != 2'h2);
    assign o_valid = (cnt_r != 2'h0);
    assign o_data  = mem_r[rp_r];
    assign push    = i_valid & o_ready;
    assign pop     = o_valid & i_ready;

    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wp_r     <= 1'b0;
            rp_r     <= 1'b0;
            cnt_r    <= 2'h0;
            mem_r[0] <= {W{1'b0}};
            mem_r[1] <= {W{1'b0}};
        end else begin
            if (push) begin
                mem_r[wp_r] <= i_data;
                wp_r        <= ~wp_r;
            end
            if (pop) begin
                rp_r <= ~rp_r;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 2'h1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 2'h1;
            end
        end
    end
endmodule

// ---- verif/ctrl_model.sv ----
/* Memory controller model: drives the command pins and the beat ready.
   Assumes the bench calls its tasks from one process. */
`timescale 1ns/100ps
module ctrl_model (
    input  wire        i_mclk,
    input  wire        i_stall,
    output reg         o_cke,
    output reg  [3:0]  o_cmd_b,
    output reg  [1:0]  o_ba,
    output reg  [12:0] o_addr,
    output reg         o_col_ready
);
    reg [1:0] cyc_r;
    initial begin
        o_cke = 1'h1;
        o_cmd_b = 4'hF;
        o_ba = 2'h0;
        o_addr = 13'h0000;
        o_col_ready = 1'h1;
        cyc_r = 2'h0;
    end
    // Address flips once deselected, so a stale value is never trusted
    task issue(input [3:0] cmd, input [1:0] ba, input [12:0] a,
               input cke);
        begin
            @(posedge i_mclk);
            o_cmd_b <= cmd;
            o_ba <= ba;
            o_addr <= a;
            o_cke <= cke;
            @(posedge i_mclk);
            o_cmd_b <= 4'hF;
            o_addr <= ~a;
        end
    endtask
    // Strobes all low; issued only with no burst running
    task mode_set(input [1:0] ba, input [12:0] a);
        begin
            issue(4'h0, ba, a, 1'h1);
            repeat (2) @(posedge i_mclk);
        end
    endtask
    // Receiver stalls two cycles in four while asked to
    always @(posedge i_mclk) begin
        cyc_r <= cyc_r + 2'h1;
        o_col_ready <= !(i_stall && cyc_r[1]);
    end
endmodule

// ---- verif/ddr_mode_config_burst_logic_props.sv ----
/* Checker of the mode and burst logic.
   Assumes it sees only the top module's ports, bound below. */
`timescale 1ns/100ps
module ddr_mode_config_burst_logic_props #(
    parameter COL_W = 10
) (
    input wire             i_mclk,
    input wire             i_rst_b,
    input wire             i_cke,
    input wire             i_cs_b,
    input wire             i_ras_b,
    input wire             i_cas_b,
    input wire             i_we_b,
    input wire [1:0]       i_ba,
    input wire [12:0]      i_addr,
    input wire             o_col_valid,
    input wire             i_col_ready,
    input wire [COL_W-1:0] o_col,
    input wire             o_col_write,
    input wire             o_col_last,
    input wire             o_cmd_ready,
    input wire             o_rd_first,
    input wire             o_rd_half,
    input wire [2:0]       o_burst_len_code,
    input wire             o_interleave,
    input wire [2:0]       o_cas_lat_code,
    input wire             o_half_drive,
    input wire             o_dll_on,
    input wire             o_dll_locked,
    input wire             o_self_refresh
);
    localparam int LOCK_N = 200;
    reg  [8:0] lock_cnt_r;
    wire       mrs = i_cke && !i_cs_b && !i_ras_b && !i_cas_b && !i_we_b;
    wire       rd = !i_cs_b && i_ras_b && !i_cas_b && i_we_b;
    wire       rw = !i_cs_b && i_ras_b && !i_cas_b;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    sequence sref_entry;
        !i_cke && !i_cs_b && !i_ras_b && !i_cas_b && i_we_b;
    endsequence
    sequence beat_held;
        o_col_valid && $stable(o_col) && $stable(o_col_last)
            && $stable(o_col_write);
    endsequence
    // Cycles spent locking; cleared when off or locked
    always @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b)
            lock_cnt_r <= 9'h000;
        else if (!o_dll_on || o_dll_locked)
            lock_cnt_r <= 9'h000;
        else
            lock_cnt_r <= lock_cnt_r + 9'h001;
    end
    chk_len_latch: assert property (
        mrs && i_ba == 2'h0 |=> o_burst_len_code == $past(i_addr[2:0])
            && o_cas_lat_code == $past(i_addr[6:4]))
        else $error("mode fields not latched");
    chk_type_latch: assert property (
        mrs && i_ba == 2'h0 |=> o_interleave == $past(i_addr[3]))
        else $error("burst type not latched");
    chk_ext_latch: assert property (
        mrs && i_ba == 2'h1 |=> o_half_drive == $past(i_addr[1]))
        else $error("drive bit not latched");
    chk_ext_held: assert property (
        !(mrs && i_ba == 2'h1) |=> $stable(o_half_drive))
        else $error("drive bit changed");
    chk_sref_dll_off: assert property (
        sref_entry |=> o_self_refresh && !o_dll_on)
        else $error("dll on in self refresh");
    chk_lock_count: assert property (
        $rose(o_dll_locked) |-> lock_cnt_r == LOCK_N)
        else $error("lock time wrong");
    chk_rd_lat_two: assert property (
        rd && (o_cas_lat_code == 3'h2 || o_cas_lat_code == 3'h6)
        |-> ##2 (o_rd_first && o_rd_half == (o_cas_lat_code == 3'h6)))
        else $error("read latency two wrong");
    chk_rd_lat_three: assert property (
        rd && o_cas_lat_code == 3'h3 |-> ##3 o_rd_first)
        else $error("read latency three wrong");
    chk_beat_stall: assert property (
        o_col_valid && !i_col_ready |=> beat_held)
        else $error("stalled beat lost");
    chk_first_beat: assert property (
        rw && o_cmd_ready && !o_col_valid |-> ##2 o_col_valid
            && o_col == $past(i_addr[COL_W-1:0], 2)
            && o_col_write == !$past(i_we_b, 2))
        else $error("first beat wrong");
endmodule
bind ddr_mode_config_burst_logic ddr_mode_config_burst_logic_props #(
    .COL_W(COL_W)) props_i (.i_mclk, .i_rst_b, .i_cke, .i_cs_b, .i_ras_b,
    .i_cas_b, .i_we_b, .i_ba, .i_addr, .o_col_valid, .i_col_ready, .o_col,
    .o_col_write, .o_col_last, .o_cmd_ready, .o_rd_first, .o_rd_half,
    .o_burst_len_code, .o_interleave, .o_cas_lat_code, .o_half_drive,
    .o_dll_on, .o_dll_locked, .o_self_refresh);

// ---- verif/ddr_mode_config_burst_logic_tb.sv ----
/* Bench of the mode and burst logic: mode writes, DLL, bursts, latency.
   Assumes the controller model drives all command pins. */
`timescale 1ns/100ps
module ddr_mode_config_burst_logic_tb;
    reg         i_mclk;
    reg         i_rst_b;
    reg         stall;
    wire        cke, col_ready, col_valid, col_write, col_last;
    wire        rd_first, rd_half, intl, half_drv, dll_on, dll_lock, sref;
    wire [3:0]  cmd_b;
    wire [1:0]  ba;
    wire [12:0] addr;
    wire [9:0]  col;
    wire [2:0]  bl_code;
    wire        mres, swb;
    reg  [9:0]  start, msk, low;
    reg  [2:0]  lat;
    integer     n_errors, n_checks, cyc, i, j, k, m, l, g, t, s;
    ctrl_model ctrl_model_i (.i_mclk(i_mclk), .i_stall(stall), .o_cke(cke),
        .o_cmd_b(cmd_b), .o_ba(ba), .o_addr(addr), .o_col_ready(col_ready));
    ddr_mode_config_burst_logic ddr_mode_config_burst_logic_i (
        .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_cke(cke), .i_cs_b(cmd_b[3]),
        .i_ras_b(cmd_b[2]), .i_cas_b(cmd_b[1]), .i_we_b(cmd_b[0]),
        .i_ba(ba), .i_addr(addr), .o_col_valid(col_valid),
        .i_col_ready(col_ready), .o_col(col), .o_col_write(col_write),
        .o_col_last(col_last), .o_cmd_ready(), .o_rd_first(rd_first),
        .o_rd_half(rd_half), .o_burst_len_code(bl_code),
        .o_interleave(intl), .o_cas_lat_code(), .o_mode_reserved(mres),
        .o_half_drive(half_drv), .o_switch_bit_set(swb), .o_dll_on(dll_on),
        .o_dll_locked(dll_lock), .o_self_refresh(sref));
    initial begin
        i_mclk = 1'h0;
        forever #2.5 i_mclk = ~i_mclk;
    end
    task check(input string name, input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("unexpected %s expected %0h seen %0h", name, exp,
                         seen);
            end
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d errors %0d", n_checks, n_errors);
            if (n_errors == 0 && n_checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // Commands wait for lock
    task wait_lock;
        begin
            for (j = 0; j < 300 && dll_lock !== 1'h1; j = j + 1)
                @(negedge i_mclk);
            check("dll locked", dll_lock, 1'h1);
        end
    endtask
    // Odd starts write, even read, under one programmed length
    task burst(input [2:0] code, input typ, input [2:0] st);
        begin
            ctrl_model_i.mode_set(2'h0, {6'h00, 3'h2, typ, code});
            check("type", intl, typ);
            start = {7'h55, st};
            stall <= typ;
            ctrl_model_i.issue(st[0] ? 4'h4 : 4'h5, 2'h0, {3'h0, start},
                               1'h1);
            l = 1 << code;
            msk = l[9:0] - 10'h001;
            k = 0;
            for (g = 0; k < l && g < 60; g = g + 1) begin
                @(negedge i_mclk);
                if (col_valid === 1'h1 && col_ready === 1'h1) begin
                    low = typ ? ({7'h00, st} ^ k[9:0]) : ({7'h00, st} + k[9:0]);
                    check("column", col, (start & ~msk) | (low & msk));
                    check("last", col_last, k == l - 1);
                    check("write", col_write, st[0]);
                    k = k + 1;
                end
            end
            check("beats", k, l);
        end
    endtask
    always @(posedge i_mclk) begin
        cyc = cyc + 1;
        if (cyc == 6000) begin
            n_errors = n_errors + 1;
            stop_test;
        end
    end
    initial begin
        i_rst_b = 1'h0;
        stall = 1'h0;
        n_errors = 0;
        n_checks = 0;
        cyc = 0;
        repeat (8) @(posedge i_mclk);
        i_rst_b <= 1'h1;
        @(negedge i_mclk);
        check("reset length", bl_code, 3'h1);
        check("reset drive", half_drv, 1'h0);
        check("reserved", mres, 1'h0);
        wait_lock;
        ctrl_model_i.mode_set(2'h1, 13'h0001);
        check("dll off", dll_on, 1'h0);
        ctrl_model_i.mode_set(2'h1, 13'h0002);
        check("half drive", half_drv, 1'h1);
        check("switch bit", swb, 1'h0);
        wait_lock;
        ctrl_model_i.mode_set(2'h2, 13'h0000);
        ctrl_model_i.mode_set(2'h0, 13'h0021);
        check("drive held", half_drv, 1'h1);
        ctrl_model_i.issue(4'h1, 2'h0, 13'h0000, 1'h0);
        @(negedge i_mclk);
        check("self refresh", sref, 1'h1);
        check("dll in sref", dll_on, 1'h0);
        ctrl_model_i.issue(4'hF, 2'h0, 13'h0000, 1'h1);
        repeat (3) @(negedge i_mclk);
        check("dll after sref", dll_on, 1'h1);
        wait_lock;
        ctrl_model_i.mode_set(2'h1, 13'h0000);
        for (t = 1; t < 4; t = t + 1)
            for (s = 0; s < 16; s = s + 1)
                burst(t[2:0], s[3], s[2:0]);
        @(posedge i_mclk);
        stall <= 1'h0;
        // Half-cycle latency shows as a flag on the whole-cycle pulse
        for (i = 0; i < 4; i = i + 1) begin
            lat = (i == 0) ? 3'h2 : (i == 1) ? 3'h6 : (i == 2) ? 3'h3 : 3'h5;
            ctrl_model_i.mode_set(2'h0, {6'h00, lat, 4'h1});
            ctrl_model_i.issue(4'h5, 2'h0, 13'h0000, 1'h1);
            m = 0;
            for (j = 1; j < 6; j = j + 1) begin
                @(negedge i_mclk);
                if (rd_first === 1'h1 && m == 0) begin
                    m = j;
                    check("half", rd_half, i == 1 || i == 3);
                end
            end
            check("latency", m, (i == 2) ? 3 : (i == 3) ? 1 : 2);
        end
        stop_test;
    end
endmodule
